/* File: logic/xfer_unit_cfg.svh */
/*
 * constants of the transfer instruction unit: opcodes, cycle counts, reset values.
 * assumes: included by the unit only; one memory byte per access.
 */
// Behaviour
// - sixteen-bit primary accumulator, upper and lower bytes, used as byte or word
// - sixteen-bit temporary accumulator with separate upper and lower bytes
// - index, extra pointer, program counter, stack pointer, status word all sixteen bits
// - status word holds eight-bit condition byte and five-bit bank pointer
// - eight bank registers chosen by opcode low three bits
// - operands: direct, offset, extended, pointer-indirect, bit address plus bit number
// - byte load copies old low accumulator to low temporary; sets N and Z
// - word load copies whole old accumulator to temporary first
// - word load big-endian: addressed byte to upper half; direct form C5
// - word store writes upper half first, lower to next address; direct D5
// - indexed byte store 46 writes to index plus offset, four cycles
// - opcode 83 stores temporary word at address held in accumulator
// - A0-A7 clear, A8-AF set one direct bit, flags untouched
// - only marked flags change; status load from accumulator sets all four
// - operand bytes follow in assembler order
// - word moves into accumulator put source upper byte in upper half
// - cycle counts are instruction cycles
`ifndef XFER_UNIT_CFG_SVH
`define XFER_UNIT_CFG_SVH

`define OP_MOV_DIR_A    8'h45
`define OP_MOV_IX_A     8'h46
`define OP_MOV_EXT_A    8'h61
`define OP_MOV_EP_A     8'h47
`define OP_MOV_A_IMM    8'h04
`define OP_MOV_A_DIR    8'h05
`define OP_MOV_A_IX     8'h06
`define OP_MOV_A_EXT    8'h60
`define OP_MOV_A_ATA    8'h92
`define OP_MOV_A_EP     8'h07
`define OP_MOV_DIR_IMM  8'h85
`define OP_MOV_EP_IMM   8'h87
`define OP_WORD_TRANSFER_OP_DIR_A   8'hD5
`define OP_WORD_TRANSFER_OP_EXT_A   8'hD4
`define OP_WORD_TRANSFER_OP_EP_A    8'hD7
`define OP_WORD_TRANSFER_OP_A_IMM   8'hE4
`define OP_WORD_TRANSFER_OP_A_DIR   8'hC5
`define OP_WORD_TRANSFER_OP_A_EXT   8'hC4
`define OP_WORD_TRANSFER_OP_A_EP    8'hC7
`define OP_WORD_TRANSFER_OP_EP_A2   8'hE3
`define OP_WORD_TRANSFER_OP_IX_A2   8'hE2
`define OP_WORD_TRANSFER_OP_SP_A2   8'hE1
`define OP_WORD_TRANSFER_OP_A_EPR   8'hF3
`define OP_WORD_TRANSFER_OP_A_IXR   8'hF2
`define OP_WORD_TRANSFER_OP_A_SPR   8'hF1
`define OP_WORD_TRANSFER_OP_A_PCR   8'hF0
`define OP_WORD_TRANSFER_OP_A_PS    8'h70
`define OP_WORD_TRANSFER_OP_PS_A    8'h71
`define OP_WORD_TRANSFER_OP_ATA_T   8'h83
`define OP_WORD_TRANSFER_OP_EP_IMM  8'hE7
`define OP_WORD_TRANSFER_OP_IX_IMM  8'hE6
`define OP_WORD_TRANSFER_OP_SP_IMM  8'hE5
`define OP_SWAP         8'h10
`define OP_XCHW_A_T     8'h43

// high five bits of register-indexed and bit-indexed groups
`define GRP_MOV_RI_A    5'h09
`define GRP_MOV_A_RI    5'h01
`define GRP_BIT_CLR     5'h14
`define GRP_BIT_SET     5'h15

// instruction cycles for fixed-length groups
`define CYC_BIT         3'd4
`define CYC_RI          3'd3

// bank register file base: bank pointer times eight, plus offset
`define BANK_BASE       16'h0100

`define RST_WORD        16'h0000
`define RST_SP          16'h0000
`define RST_CCR         8'h00
`define RST_BANK        5'h00

`define FLAG_N          3
`define FLAG_Z          2
`define FLAG_V          1
`define FLAG_C          0

`endif

/* File: logic/xfer_unit_pkg.sv */
/*
 * types of the transfer instruction unit.
 * assumes: constants come from xfer_unit_cfg.svh.
 */
package xfer_unit_pkg;
	typedef enum logic [2:0] {
		ST_FETCH,
		ST_OPND,
		ST_MEM,
		ST_WAIT
	} phase_t;

	typedef struct packed {
		phase_t      phase;
		logic [7:0]  opcode;
		logic [2:0]  step;
		logic [2:0]  cycles;
		logic [15:0] addr;
		logic [7:0]  opnd;
		logic [15:0] acc;
		logic [15:0] tmp;
		logic [15:0] ix;
		logic [15:0] ep;
		logic [15:0] pc;
		logic [15:0] sp;
		logic [7:0]  condition_code_byte;
		logic [4:0]  bank;
		logic [15:0] mem_addr;
		logic [7:0]  mem_wdata;
		logic        mem_rd;
		logic        mem_wr;
		logic        illegal;
	} state_t;
endpackage : xfer_unit_pkg

/* File: logic/xfer_unit.sv */
/*
 * transfer instruction unit: fetches and executes the data transfer group.
 * assumes: two clocks per instruction cycle, five-cycle words held to eight clocks; memory returns read data the next cycle.
 */
`include "xfer_unit_cfg.svh"

module xfer_unit (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rstn,
	input  wire logic [7:0]  i_mem_rdata,
	output logic      [15:0] o_mem_addr,
	output logic      [7:0]  o_mem_wdata,
	output logic             o_mem_rd,
	output logic             o_mem_wr,
	output logic      [15:0] o_primary_acc,
	output logic      [15:0] o_temp_acc,
	output logic      [15:0] o_program_status_word,
	output logic             o_illegal_op
);
	xfer_unit_pkg::state_t s;
	xfer_unit_pkg::state_t next_s;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [7:0] nz_flags(input logic [7:0] condition_code_byte, input logic [15:0] v, input logic wide);
		logic [7:0] r;
		r = condition_code_byte;
		r[`FLAG_N] = wide ? v[15] : v[7];
		r[`FLAG_Z] = wide ? (v == 16'h0000) : (v[7:0] == 8'h00);
		return r;
	endfunction : nz_flags

	function automatic logic [15:0] bank_addr(input logic [4:0] bank, input logic [2:0] idx);
		return `BANK_BASE + {8'h00, bank, idx};
	endfunction : bank_addr

	// listed cycles, zero for an unsupported code
	function automatic logic [2:0] cycle_count(input logic [7:0] op);
		logic [2:0] c;
		c = 3'd0;
		unique case (op[7:3])
			`GRP_MOV_RI_A, `GRP_MOV_A_RI: c = `CYC_RI;
			`GRP_BIT_CLR, `GRP_BIT_SET:   c = `CYC_BIT;
			default: begin
				unique case (op)
					`OP_MOV_A_IMM, `OP_WORD_TRANSFER_OP_EP_A2, `OP_WORD_TRANSFER_OP_IX_A2, `OP_WORD_TRANSFER_OP_SP_A2,
					`OP_WORD_TRANSFER_OP_A_EPR, `OP_WORD_TRANSFER_OP_A_IXR, `OP_WORD_TRANSFER_OP_A_SPR, `OP_WORD_TRANSFER_OP_A_PCR,
					`OP_WORD_TRANSFER_OP_A_PS, `OP_WORD_TRANSFER_OP_PS_A, `OP_SWAP: c = 3'd2;
					`OP_MOV_DIR_A, `OP_MOV_EP_A, `OP_MOV_A_DIR, `OP_MOV_A_ATA, `OP_MOV_A_EP,
					`OP_WORD_TRANSFER_OP_A_IMM, `OP_WORD_TRANSFER_OP_EP_IMM, `OP_WORD_TRANSFER_OP_IX_IMM, `OP_WORD_TRANSFER_OP_SP_IMM,
					`OP_XCHW_A_T: c = 3'd3;
					`OP_MOV_IX_A, `OP_MOV_EXT_A, `OP_MOV_A_IX, `OP_MOV_A_EXT, `OP_MOV_DIR_IMM,
					`OP_MOV_EP_IMM, `OP_WORD_TRANSFER_OP_DIR_A, `OP_WORD_TRANSFER_OP_A_DIR, `OP_WORD_TRANSFER_OP_EP_A,
					`OP_WORD_TRANSFER_OP_A_EP, `OP_WORD_TRANSFER_OP_ATA_T: c = 3'd4;
					`OP_WORD_TRANSFER_OP_EXT_A, `OP_WORD_TRANSFER_OP_A_EXT: c = 3'd5;
					default: c = 3'd0;
				endcase
			end
		endcase
		return c;
	endfunction : cycle_count

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [7:0]  op;
		logic [15:0] ptr;
		op = s.opcode;
		ptr = 16'h0000;
		next_s = s;
		next_s.mem_rd = 1'b0;
		next_s.mem_wr = 1'b0;
		next_s.step = s.step + 3'd1;
		unique case (s.phase)
			xfer_unit_pkg::ST_FETCH: begin
				// step 0 issues the opcode read, step 1 latches it
				if (s.step == 3'd0) begin
					next_s.mem_addr = s.pc;
					next_s.mem_rd = 1'b1;
					next_s.pc = s.pc + 16'h0001;
				end else begin
					next_s.opcode = i_mem_rdata;
					next_s.cycles = cycle_count(i_mem_rdata);
					next_s.illegal = (cycle_count(i_mem_rdata) == 3'd0);
					next_s.phase = xfer_unit_pkg::ST_OPND;
					next_s.step = 3'd2;
				end
			end
			xfer_unit_pkg::ST_OPND: begin
				next_s.phase = xfer_unit_pkg::ST_MEM;
				unique case (op)
					// one operand byte fetched in assembler order
					`OP_MOV_DIR_A, `OP_MOV_IX_A, `OP_MOV_A_IMM, `OP_MOV_A_DIR, `OP_MOV_A_IX,
					`OP_WORD_TRANSFER_OP_DIR_A, `OP_WORD_TRANSFER_OP_A_DIR, `OP_MOV_DIR_IMM: begin
						next_s.mem_addr = s.pc;
						next_s.mem_rd = 1'b1;
						next_s.pc = s.pc + 16'h0001;
					end
					// sixteen-bit operands, upper byte first
					`OP_MOV_EXT_A, `OP_MOV_A_EXT, `OP_WORD_TRANSFER_OP_EXT_A, `OP_WORD_TRANSFER_OP_A_EXT,
					`OP_WORD_TRANSFER_OP_A_IMM, `OP_WORD_TRANSFER_OP_EP_IMM, `OP_WORD_TRANSFER_OP_IX_IMM, `OP_WORD_TRANSFER_OP_SP_IMM: begin
						next_s.mem_addr = s.pc;
						next_s.mem_rd = 1'b1;
						next_s.pc = s.pc + 16'h0002;
					end
					default: begin
						if (op[7:4] == 4'hA) begin
							next_s.mem_addr = s.pc;
							next_s.mem_rd = 1'b1;
							next_s.pc = s.pc + 16'h0001;
						end
					end
				endcase
			end
			xfer_unit_pkg::ST_MEM: begin
				// step counts clocks since fetch; actions keyed on it
				if (s.step == 3'd3) begin
					next_s.opnd = i_mem_rdata;
					unique case (op)
						`OP_MOV_A_IMM: begin
							next_s.tmp[7:0] = s.acc[7:0];
							next_s.acc[7:0] = i_mem_rdata;
							next_s.condition_code_byte = nz_flags(s.condition_code_byte, {8'h00, i_mem_rdata}, 1'b0);
						end
						`OP_MOV_DIR_A, `OP_MOV_A_DIR, `OP_WORD_TRANSFER_OP_DIR_A, `OP_WORD_TRANSFER_OP_A_DIR, `OP_MOV_DIR_IMM: begin
							next_s.addr = {8'h00, i_mem_rdata};
						end
						`OP_MOV_IX_A, `OP_MOV_A_IX: begin
							next_s.addr = s.ix + {{8{i_mem_rdata[7]}}, i_mem_rdata};
						end
						`OP_MOV_EP_IMM: next_s.addr = s.ep;
						`OP_MOV_EXT_A, `OP_MOV_A_EXT, `OP_WORD_TRANSFER_OP_EXT_A, `OP_WORD_TRANSFER_OP_A_EXT,
						`OP_WORD_TRANSFER_OP_A_IMM, `OP_WORD_TRANSFER_OP_EP_IMM, `OP_WORD_TRANSFER_OP_IX_IMM, `OP_WORD_TRANSFER_OP_SP_IMM: begin
							next_s.addr = {i_mem_rdata, 8'h00};
							next_s.mem_addr = s.mem_addr + 16'h0001;
							next_s.mem_rd = 1'b1;
						end
						`OP_MOV_EP_A: begin
							next_s.mem_addr = s.ep;
							next_s.mem_wdata = s.acc[7:0];
							next_s.mem_wr = 1'b1;
						end
						`OP_MOV_A_EP: begin
							next_s.mem_addr = s.ep;
							next_s.mem_rd = 1'b1;
						end
						`OP_MOV_A_ATA, `OP_WORD_TRANSFER_OP_ATA_T, `OP_WORD_TRANSFER_OP_EP_A, `OP_WORD_TRANSFER_OP_A_EP: begin
							ptr = (op == `OP_WORD_TRANSFER_OP_EP_A || op == `OP_WORD_TRANSFER_OP_A_EP) ? s.ep : s.acc;
							next_s.addr = ptr;
							next_s.mem_addr = ptr;
							next_s.mem_rd = (op == `OP_MOV_A_ATA || op == `OP_WORD_TRANSFER_OP_A_EP);
							next_s.mem_wr = (op == `OP_WORD_TRANSFER_OP_ATA_T || op == `OP_WORD_TRANSFER_OP_EP_A);
							next_s.mem_wdata = (op == `OP_WORD_TRANSFER_OP_ATA_T) ? s.tmp[15:8] : s.acc[15:8];
						end
						`OP_WORD_TRANSFER_OP_EP_A2: next_s.ep = s.acc;
						`OP_WORD_TRANSFER_OP_IX_A2: next_s.ix = s.acc;
						`OP_WORD_TRANSFER_OP_SP_A2: next_s.sp = s.acc;
						`OP_WORD_TRANSFER_OP_A_EPR: next_s.acc = s.ep;
						`OP_WORD_TRANSFER_OP_A_IXR: next_s.acc = s.ix;
						`OP_WORD_TRANSFER_OP_A_SPR: next_s.acc = s.sp;
						`OP_WORD_TRANSFER_OP_A_PCR: next_s.acc = s.pc;
						`OP_WORD_TRANSFER_OP_A_PS: next_s.acc = {3'b000, s.bank, s.condition_code_byte};
						`OP_WORD_TRANSFER_OP_PS_A: begin
							next_s.bank = s.acc[12:8];
							next_s.condition_code_byte = s.acc[7:0];
						end
						`OP_SWAP: next_s.acc = {s.acc[7:0], s.acc[15:8]};
						`OP_XCHW_A_T: begin
							next_s.acc = s.tmp;
							next_s.tmp = s.acc;
						end
						default: begin
							if (op[7:3] == `GRP_MOV_RI_A) begin
								next_s.mem_addr = bank_addr(s.bank, op[2:0]);
								next_s.mem_wdata = s.acc[7:0];
								next_s.mem_wr = 1'b1;
							end else if (op[7:3] == `GRP_MOV_A_RI) begin
								next_s.mem_addr = bank_addr(s.bank, op[2:0]);
								next_s.mem_rd = 1'b1;
							end
						end
					endcase
				end else if (s.step == 3'd4) begin
					unique case (op)
						`OP_MOV_DIR_A, `OP_MOV_IX_A: begin
							next_s.mem_addr = s.addr;
							next_s.mem_wdata = s.acc[7:0];
							next_s.mem_wr = 1'b1;
						end
						`OP_MOV_DIR_IMM, `OP_MOV_EP_IMM: begin
							next_s.mem_addr = s.pc;
							next_s.mem_rd = 1'b1;
							next_s.pc = s.pc + 16'h0001;
						end
						`OP_MOV_A_DIR, `OP_MOV_A_IX, `OP_WORD_TRANSFER_OP_A_DIR: begin
							next_s.mem_addr = s.addr;
							next_s.mem_rd = 1'b1;
						end
						`OP_WORD_TRANSFER_OP_DIR_A, `OP_WORD_TRANSFER_OP_EP_A, `OP_WORD_TRANSFER_OP_ATA_T: begin
							next_s.mem_addr = s.addr + ((op == `OP_WORD_TRANSFER_OP_DIR_A) ? 16'h0000 : 16'h0001);
							next_s.mem_wdata = (op == `OP_WORD_TRANSFER_OP_DIR_A) ? s.acc[15:8] :
								(op == `OP_WORD_TRANSFER_OP_ATA_T) ? s.tmp[7:0] : s.acc[7:0];
							next_s.mem_wr = 1'b1;
						end
						`OP_WORD_TRANSFER_OP_A_EP: begin
							next_s.opnd = i_mem_rdata;
							next_s.mem_addr = s.addr + 16'h0001;
							next_s.mem_rd = 1'b1;
						end
						`OP_MOV_A_EP, `OP_MOV_A_ATA: begin
							next_s.tmp[7:0] = s.acc[7:0];
							next_s.acc[7:0] = i_mem_rdata;
							next_s.condition_code_byte = nz_flags(s.condition_code_byte, {8'h00, i_mem_rdata}, 1'b0);
						end
						`OP_WORD_TRANSFER_OP_A_IMM, `OP_WORD_TRANSFER_OP_EP_IMM, `OP_WORD_TRANSFER_OP_IX_IMM, `OP_WORD_TRANSFER_OP_SP_IMM: begin
							unique case (op)
								`OP_WORD_TRANSFER_OP_A_IMM: begin
									next_s.tmp = s.acc;
									next_s.acc = {s.addr[15:8], i_mem_rdata};
								end
								`OP_WORD_TRANSFER_OP_EP_IMM: next_s.ep = {s.addr[15:8], i_mem_rdata};
								`OP_WORD_TRANSFER_OP_IX_IMM: next_s.ix = {s.addr[15:8], i_mem_rdata};
								default: next_s.sp = {s.addr[15:8], i_mem_rdata};
							endcase
						end
						`OP_MOV_EXT_A, `OP_MOV_A_EXT, `OP_WORD_TRANSFER_OP_EXT_A, `OP_WORD_TRANSFER_OP_A_EXT: begin
							next_s.addr = {s.addr[15:8], i_mem_rdata};
							next_s.mem_addr = {s.addr[15:8], i_mem_rdata};
							next_s.mem_rd = (op == `OP_MOV_A_EXT || op == `OP_WORD_TRANSFER_OP_A_EXT);
							next_s.mem_wr = (op == `OP_MOV_EXT_A || op == `OP_WORD_TRANSFER_OP_EXT_A);
							next_s.mem_wdata = (op == `OP_MOV_EXT_A) ? s.acc[7:0] : s.acc[15:8];
						end
						default: begin
							if (op[7:3] == `GRP_MOV_A_RI) begin
								next_s.tmp[7:0] = s.acc[7:0];
								next_s.acc[7:0] = i_mem_rdata;
								next_s.condition_code_byte = nz_flags(s.condition_code_byte, {8'h00, i_mem_rdata}, 1'b0);
							end else if (op[7:4] == 4'hA) begin
								next_s.mem_addr = {8'h00, s.opnd};
								next_s.mem_rd = 1'b1;
							end
						end
					endcase
				end else if (s.step == 3'd5) begin
					unique case (op)
						`OP_MOV_DIR_IMM, `OP_MOV_EP_IMM: begin
							next_s.mem_addr = s.addr;
							next_s.mem_wdata = i_mem_rdata;
							next_s.mem_wr = 1'b1;
						end
						`OP_MOV_A_DIR, `OP_MOV_A_IX, `OP_MOV_A_EXT: begin
							next_s.tmp[7:0] = s.acc[7:0];
							next_s.acc[7:0] = i_mem_rdata;
							next_s.condition_code_byte = nz_flags(s.condition_code_byte, {8'h00, i_mem_rdata}, 1'b0);
						end
						`OP_WORD_TRANSFER_OP_A_DIR, `OP_WORD_TRANSFER_OP_A_EXT: begin
							next_s.opnd = i_mem_rdata;
							next_s.mem_addr = s.addr + 16'h0001;
							next_s.mem_rd = 1'b1;
						end
						`OP_WORD_TRANSFER_OP_EXT_A, `OP_WORD_TRANSFER_OP_DIR_A: begin
							next_s.mem_addr = s.addr + 16'h0001;
							next_s.mem_wdata = s.acc[7:0];
							next_s.mem_wr = 1'b1;
						end
						`OP_WORD_TRANSFER_OP_A_EP: begin
							next_s.tmp = s.acc;
							next_s.acc = {s.opnd, i_mem_rdata};
							next_s.condition_code_byte = nz_flags(s.condition_code_byte, {s.opnd, i_mem_rdata}, 1'b1);
						end
						default: begin
							if (op[7:4] == 4'hA) begin
								next_s.mem_addr = {8'h00, s.opnd};
								next_s.mem_wdata = i_mem_rdata;
								next_s.mem_wdata[op[2:0]] = op[3];
								next_s.mem_wr = 1'b1;
							end
						end
					endcase
				end else if (s.step == 3'd6) begin
					if (op == `OP_WORD_TRANSFER_OP_A_DIR || op == `OP_WORD_TRANSFER_OP_A_EXT) begin
						next_s.tmp = s.acc;
						next_s.acc = {s.opnd, i_mem_rdata};
						next_s.condition_code_byte = nz_flags(s.condition_code_byte, {s.opnd, i_mem_rdata}, 1'b1);
					end
				end
				// last step is 2*cycles-1; five-cycle words share the final step 7
				if (s.step >= ((s.cycles >= 3'd4) ? 3'd7 : {s.cycles[1:0] - 2'd1, 1'b1}) || s.illegal) begin
					next_s.phase = xfer_unit_pkg::ST_FETCH;
					next_s.step = 3'd0;
				end
			end
			default: begin
				next_s.phase = xfer_unit_pkg::ST_FETCH;
				next_s.step = 3'd0;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s <= '0;
			s.sp <= `RST_SP;
			s.condition_code_byte <= `RST_CCR;
			s.bank <= `RST_BANK;
		end else begin
			s <= next_s;
		end
	end

	assign o_mem_addr = s.mem_addr;
	assign o_mem_wdata = s.mem_wdata;
	assign o_mem_rd = s.mem_rd;
	assign o_mem_wr = s.mem_wr;
	assign o_primary_acc = s.acc;
	assign o_temp_acc = s.tmp;
	assign o_program_status_word = {3'b000, s.bank, s.condition_code_byte};
	assign o_illegal_op = s.illegal;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_strobe_excl: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) !(o_mem_rd && o_mem_wr))
		else $error("read and write strobes together");
	a_bitop_flags: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		(s.phase == xfer_unit_pkg::ST_MEM && s.opcode[7:4] == 4'hA) |=> $stable(s.condition_code_byte))
		else $error("bit operation changed flags");
	a_store_flags: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		(o_mem_wr && s.opcode != `OP_WORD_TRANSFER_OP_PS_A) |-> $stable(s.condition_code_byte))
		else $error("store changed flags");
	a_bank_wr: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		(o_mem_wr && s.opcode[7:3] == `GRP_MOV_RI_A) |-> o_mem_addr[2:0] == s.opcode[2:0])
		else $error("bank register index wrong");
	a_byte_load: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		(s.phase == xfer_unit_pkg::ST_MEM && s.opcode == `OP_MOV_A_IMM)
		|=> (o_temp_acc[7:0] == $past(o_primary_acc[7:0]) && $stable(o_temp_acc[15:8])))
		else $error("byte load did not keep the old low byte");
	a_word_store: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		(o_mem_wr && s.opcode == `OP_WORD_TRANSFER_OP_DIR_A && s.step == 3'd5) |-> o_mem_wdata == s.acc[15:8]
		##1 (o_mem_wr && o_mem_wdata == s.acc[7:0] && o_mem_addr == s.addr + 16'h0001))
		else $error("word store byte order wrong");
endmodule : xfer_unit

/* File: test/mem_model.sv */
/*
 * behavioural byte memory on the far side of the transfer unit.
 * assumes: read data stands while the read strobe is high; writes land on the strobe edge.
 */
module mem_model (
	input  wire logic        i_ref_clk,
	input  wire logic [15:0] i_mem_addr,
	input  wire logic [7:0]  i_mem_wdata,
	input  wire logic        i_mem_rd,
	input  wire logic        i_mem_wr,
	output logic      [7:0]  o_mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] mem [0:65535];
	logic [7:0] last_rdata = 8'h00;

	// ----------------------------------------
	// read and write port
	// ----------------------------------------
	// inverse of the last read outside a read, so stale data never passes
	assign o_mem_rdata = i_mem_rd ? mem[i_mem_addr] : ~last_rdata;

	always @(posedge i_ref_clk) begin
		if (i_mem_rd)
			last_rdata <= mem[i_mem_addr];
		if (i_mem_wr)
			mem[i_mem_addr] <= i_mem_wdata;
	end
endmodule : mem_model

/* File: test/xfer_unit_tb.sv */
/*
 * self-checking bench of the transfer instruction unit.
 * assumes: programs start at 0x0000 and end on an unsupported opcode (0xFF fill).
 */
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("Error t=%0t got %h expected %h", $time, got, exp); end end

module xfer_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk          = 1'b0;
	logic        rstn         = 1'b0;
	logic [7:0]  mem_rdata;
	logic [15:0] mem_addr;
	logic [7:0]  mem_wdata;
	logic        mem_rd;
	logic        mem_wr;
	logic [15:0] acc;
	logic [15:0] tmp;
	logic [15:0] psw;
	logic        illegal;
	int          n_mismatch   = 0;
	int          total_checks = 0;
	int          cycles       = 0;
	int          run_edges    = 0;

	xfer_unit xfer_unit_i (
		.i_ref_clk            (clk),
		.i_rstn               (rstn),
		.i_mem_rdata          (mem_rdata),
		.o_mem_addr           (mem_addr),
		.o_mem_wdata          (mem_wdata),
		.o_mem_rd             (mem_rd),
		.o_mem_wr             (mem_wr),
		.o_primary_acc        (acc),
		.o_temp_acc           (tmp),
		.o_program_status_word(psw),
		.o_illegal_op         (illegal)
	);

	mem_model mem_model_i (
		.i_ref_clk  (clk),
		.i_mem_addr (mem_addr),
		.i_mem_wdata(mem_wdata),
		.i_mem_rd   (mem_rd),
		.i_mem_wr   (mem_wr),
		.o_mem_rdata(mem_rdata)
	);

	always #20 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			$display("Error t=%0t run did not finish", $time);
			complete_run();
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task complete_run();
		$display("mismatches %0d checks %0d", n_mismatch, total_checks);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	task load(input logic [15:0] base, input logic [7:0] b [$]);
		foreach (b[k])
			mem_model_i.mem[base + 16'(k)] = b[k];
	endtask : load

	task clear();
		for (int a = 0; a < 1024; a++)
			mem_model_i.mem[a] = 8'hFF;
	endtask : clear

	// reset, then run until the closing unsupported opcode
	task execute();
		int k;
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`CHK(acc, 16'h0000)
		`CHK(tmp, 16'h0000)
		`CHK(psw, 16'h0000)
		`CHK({mem_rd, mem_wr, mem_addr}, 18'h00000)
		@(posedge clk);
		rstn <= 1'b1;
		for (k = 0; k < 300; k++) begin
			@(posedge clk);
			#1;
			if (illegal === 1'b1)
				break;
		end
		run_edges = k + 1;
		`CHK(illegal, 1'b1)
		#1;
	endtask : execute

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_byte_load();
		clear();
		load(16'h0000, '{8'hE4, 8'h12, 8'h34, 8'h04, 8'h80});
		execute();
		`CHK(acc, 16'h1280)
		`CHK(tmp, 16'h0034)
		`CHK(psw, 16'h0008)
		`CHK(run_edges, 12)
	endtask : t_byte_load

	task t_word_load();
		clear();
		load(16'h0000, '{8'hE4, 8'h11, 8'h22, 8'hC5, 8'h40});
		load(16'h0040, '{8'hA5, 8'h00});
		execute();
		`CHK(acc, 16'hA500)
		`CHK(tmp, 16'h1122)
		`CHK(psw, 16'h0008)
	endtask : t_word_load

	task t_stores();
		clear();
		load(16'h0000, '{8'hE4, 8'h00, 8'h0F, 8'h71, 8'hE4, 8'hBE, 8'hEF, 8'hD5, 8'h50,
			8'hE6, 8'h02, 8'h00, 8'h46, 8'h05});
		execute();
		`CHK(mem_model_i.mem[16'h0050], 8'hBE)
		`CHK(mem_model_i.mem[16'h0051], 8'hEF)
		`CHK(mem_model_i.mem[16'h0205], 8'hEF)
		`CHK(psw, 16'h000F)
	endtask : t_stores

	task t_store_temp();
		clear();
		load(16'h0000, '{8'hE4, 8'h12, 8'h34, 8'hE4, 8'h00, 8'h60, 8'h83});
		execute();
		`CHK(mem_model_i.mem[16'h0060], 8'h12)
		`CHK(mem_model_i.mem[16'h0061], 8'h34)
		`CHK(tmp, 16'h1234)
		`CHK(acc, 16'h0060)
	endtask : t_store_temp

	task t_bits();
		for (int b = 0; b < 8; b++) begin
			clear();
			load(16'h0000, '{8'hE4, 8'h00, 8'h05, 8'h71, {5'h14, 3'(b)}, 8'h30, {5'h15, 3'(b)}, 8'h31});
			load(16'h0030, '{8'hFF, 8'h00});
			execute();
			`CHK(mem_model_i.mem[16'h0030], ~(8'h01 << b))
			`CHK(mem_model_i.mem[16'h0031], 8'h01 << b)
			`CHK(psw, 16'h0005)
		end
	endtask : t_bits

	task t_status_bank();
		clear();
		load(16'h0000, '{8'hE4, 8'h1F, 8'h0A, 8'h71, 8'hE4, 8'h00, 8'h00, 8'h70, 8'h04, 8'h9C, 8'h4B});
		execute();
		`CHK(psw, 16'h1F0A)
		`CHK(acc, 16'h1F9C)
		`CHK(tmp, 16'h1F0A)
		`CHK(mem_model_i.mem[16'h01FB], 8'h9C)
	endtask : t_status_bank

	initial begin
		repeat (2) @(posedge clk);
		t_byte_load();
		t_word_load();
		t_stores();
		t_store_temp();
		t_bits();
		t_status_bank();
		complete_run();
	end
endmodule : xfer_unit_tb
